// File: logic/pmeq_top.sv
// top of the per-monitor enable qualifier: apb registers, counters, capture units
// assumes core-side inputs come from logic on REF_CLK; apb master on the same clock
`timescale 1ns/100ps
module pmeq_top
    import pmeq_pkg::*;
(
    input  wire logic                REF_CLK,
    input  wire logic                RESETN,
    input  wire logic                PSEL,
    input  wire logic                PENABLE,
    input  wire logic                PWRITE,
    input  wire logic [11:0]         PADDR,
    input  wire logic [31:0]         PWDATA,
    output logic [31:0]              PRDATA,
    output logic                     PREADY,
    output logic                     PSLVERR,
    input  wire logic [1:0]          CUR_PRIV_LEVEL,
    input  wire logic                INSTR_SET,
    input  wire logic                SET_USER_MASK,
    input  wire logic                RESET_USER_MASK,
    input  wire logic                INTERRUPTION_DELIVERED,
    input  wire logic [NUM_CNT-1:0]  COUNT_EVENT,
    input  wire logic                IADDR_EVENT,
    input  wire logic [31:0]         IADDR_VALUE,
    input  wire logic                DADDR_EVENT,
    input  wire logic [31:0]         DADDR_VALUE,
    output logic [NUM_MON-1:0]       MONITOR_ENABLE,
    output logic                     FROZEN,
    output logic                     MON_IRQ
);

    pmeq_state_s          s;
    pmeq_state_s          next_s;
    pmeq_psr_s            processor_status_reg;
    logic [NUM_MON-1:0]   en;
    logic                 apb_acc;
    logic                 wr_fire;
    logic [NUM_CNT-1:0]   ovf;

    // map a configuration index onto a monitor slot
    function automatic logic [2:0] slot_of(input logic [7:0] idx);
        if (idx >= CIDX_CNT_FIRST && idx <= CIDX_CNT_LAST) begin
            slot_of = 3'(idx - CIDX_CNT_FIRST);
        end else if (idx == CIDX_IEAR) begin
            slot_of = SLOT_IEAR;
        end else if (idx == CIDX_DEAR) begin
            slot_of = SLOT_DEAR;
        end else if (idx == CIDX_TRACE) begin
            slot_of = SLOT_TRACE;
        end else begin
            slot_of = NO_SLOT;
        end
    endfunction

    // word index inside a region
    function automatic logic [7:0] idx_of(input logic [11:0] addr);
        idx_of = {2'h0, addr[7:2]};
    endfunction

    // packed view of a monitor configuration word
    function automatic logic [31:0] cfg_word(input pmeq_cfg_s c);
        cfg_word = 32'h0;
        cfg_word[CFG_PLM_LSB +: 4] = c.plm;
        cfg_word[CFG_ISM_LSB +: 2] = c.ism;
        cfg_word[CFG_PM_BIT] = c.pm;
    endfunction

    // status fields that the qualifier sees
    assign processor_status_reg = '{user_monitor_enable:       s.up,
                   system_monitor_enable:     s.pp,
                   current_privilege_level:   CUR_PRIV_LEVEL,
                   instruction_set_indicator: INSTR_SET};

    pmeq_qual u_qual (
        .processor_status_reg    (processor_status_reg),
        .freeze (s.freeze),
        .cfg    (s.cfg),
        .en     (en)
    );

    assign apb_acc = PSEL && PENABLE;
    assign wr_fire = apb_acc && s.pready && PWRITE;

    // next-state logic: instructions, counting, capture, software access, hardware sets
    always_comb begin
        logic [7:0]  idx;
        logic [2:0]  slot;
        logic        hit;
        logic [31:0] rd;
        logic [32:0] sum;
        idx  = idx_of(PADDR);
        slot = slot_of(idx);
        hit  = 1'b0;
        rd   = 32'h0;
        sum  = 33'h0;
        ovf  = '0;
        next_s = s;

        // user enable from set/reset-user-mask instructions
        if (SET_USER_MASK) begin
            next_s.up = 1'b1;
        end
        if (RESET_USER_MASK) begin
            next_s.up = 1'b0;
        end

        // generic counters step only with this cycle's enable
        for (int k = 0; k < NUM_CNT; k++) begin
            if (COUNT_EVENT[k] && en[k]) begin
                sum = {1'b0, s.cnt[k]} + 33'h1;
                next_s.cnt[k] = sum[31:0];
                ovf[k] = sum[32];
            end
        end

        // capture units take an address when their monitor is enabled
        if (IADDR_EVENT && en[SLOT_IEAR]) begin
            next_s.iear_addr = IADDR_VALUE;
            next_s.iear_cnt = s.iear_cnt + 16'h1;
        end
        if (DADDR_EVENT && en[SLOT_DEAR]) begin
            next_s.dear_addr = DADDR_VALUE;
            next_s.dear_cnt = s.dear_cnt + 16'h1;
        end

        // register decode for reads and writes
        if (PADDR[11:8] == REGION_CFG) begin
            if (idx == CIDX_STATUS0) begin
                hit = 1'b1;
                rd[ST0_FRZ_BIT] = s.freeze;
                rd[ST0_OVF_LSB +: NUM_CNT] = s.sts;
                if (wr_fire) begin
                    next_s.freeze = PWDATA[ST0_FRZ_BIT];
                end
            end else if (idx <= CIDX_STATUS3) begin
                hit = 1'b1;
            end else if (slot != NO_SLOT) begin
                hit = 1'b1;
                rd = cfg_word(s.cfg[slot]);
                if (wr_fire) begin
                    next_s.cfg[slot].plm = PWDATA[CFG_PLM_LSB +: 4];
                    next_s.cfg[slot].ism = PWDATA[CFG_ISM_LSB +: 2];
                    next_s.cfg[slot].pm = PWDATA[CFG_PM_BIT];
                end
            end
        end else if (PADDR[11:8] == REGION_DATA) begin
            if (idx >= DIDX_CNT_FIRST && idx <= DIDX_CNT_LAST) begin
                hit = 1'b1;
                rd = s.cnt[2'(idx - DIDX_CNT_FIRST)];
                if (wr_fire) begin
                    next_s.cnt[2'(idx - DIDX_CNT_FIRST)] = PWDATA;
                end
            end else if (idx == DIDX_IEAR_ADDR) begin
                hit = 1'b1;
                rd = s.iear_addr;
            end else if (idx == DIDX_IEAR_CNT) begin
                hit = 1'b1;
                rd = {16'h0, s.iear_cnt};
            end else if (idx == DIDX_DEAR_ADDR) begin
                hit = 1'b1;
                rd = s.dear_addr;
            end else if (idx == DIDX_DEAR_CNT) begin
                hit = 1'b1;
                rd = {16'h0, s.dear_cnt};
            end else if ((idx >= DIDX_TRACE_FIRST && idx <= DIDX_TRACE_LAST)
                         || idx == DIDX_DEAR_EXT) begin
                hit = 1'b1;
            end
        end else if (PADDR == REG_PSR) begin
            hit = 1'b1;
            rd[USER_MONITOR_ENABLE_BIT] = s.up;
            rd[SYSTEM_MONITOR_ENABLE_BIT] = s.pp;
            rd[CURRENT_PRIVILEGE_LEVEL_LSB +: 2] = CUR_PRIV_LEVEL;
            rd[INSTRUCTION_SET_INDICATOR_BIT] = INSTR_SET;
            if (wr_fire) begin
                next_s.up = PWDATA[USER_MONITOR_ENABLE_BIT];
                if (CUR_PRIV_LEVEL == PRIV_KERNEL) begin
                    next_s.pp = PWDATA[SYSTEM_MONITOR_ENABLE_BIT];
                end
            end
        end else if (PADDR == REG_DCR) begin
            hit = 1'b1;
            rd[INTERRUPTION_MONITOR_DEFAULT_BIT] = s.interruption_monitor_default;
            if (wr_fire) begin
                next_s.interruption_monitor_default = PWDATA[INTERRUPTION_MONITOR_DEFAULT_BIT];
            end
        end else if (PADDR == REG_IRQ_STS) begin
            hit = 1'b1;
            rd[NUM_CNT-1:0] = s.sts;
        end else if (PADDR == REG_IRQ_CLR) begin
            hit = 1'b1;
            if (wr_fire) begin
                next_s.sts = s.sts & ~PWDATA[NUM_CNT-1:0];
            end
        end else if (PADDR == REG_IRQ_EN) begin
            hit = 1'b1;
            rd[NUM_CNT-1:0] = s.ien;
            if (wr_fire) begin
                next_s.ien = PWDATA[NUM_CNT-1:0];
            end
        end

        // hardware sets win over software clears
        next_s.sts = next_s.sts | ovf;
        if (|ovf) begin
            next_s.freeze = 1'b1;
        end
        if (INTERRUPTION_DELIVERED) begin
            next_s.pp = s.interruption_monitor_default;
        end

        // apb answer one cycle into the access phase
        next_s.pready = apb_acc && !s.pready;
        next_s.pslverr = apb_acc && !s.pready && !hit;
        if (apb_acc && !s.pready) begin
            next_s.prdata = rd;
        end

        next_s.irq = |(next_s.sts & next_s.ien);
        next_s.en_q = en;
    end

    // state register
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            s <= '0;
            s.up <= RST_UP;
            s.pp <= RST_PP;
            s.interruption_monitor_default <= RST_INTERRUPTION_MONITOR_DEFAULT;
            s.freeze <= RST_FREEZE;
            s.cfg <= {NUM_MON{RST_CFG}};
            s.ien <= RST_IRQ_EN;
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from flops
    assign PRDATA = s.prdata;
    assign PREADY = s.pready;
    assign PSLVERR = s.pslverr;
    assign MONITOR_ENABLE = s.en_q;
    assign FROZEN = s.freeze;
    assign MON_IRQ = s.irq;

    // helper vectors for the checks
    logic [NUM_MON-1:0] pm_vec;
    logic [NUM_MON-1:0] plm_ok;
    logic [NUM_MON-1:0] ism_ok;
    always_comb begin
        for (int k = 0; k < NUM_MON; k++) begin
            pm_vec[k] = s.cfg[k].pm;
            plm_ok[k] = s.cfg[k].plm[CUR_PRIV_LEVEL];
            ism_ok[k] = !s.cfg[k].ism[INSTR_SET] || (3'(k) == SLOT_TRACE);
        end
    end

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RESETN);

    // qualification checks
    chk_plm_gate:    assert property ((en & ~plm_ok) == '0)
        else $error("monitor enabled with privilege mask bit clear");
    chk_user_path:   assert property (!s.up |-> (en & ~pm_vec) == '0)
        else $error("user monitor enabled without user enable");
    chk_sys_path:    assert property (!s.pp |-> (en & pm_vec) == '0)
        else $error("system monitor enabled without system enable");
    chk_freeze_gate: assert property (s.freeze |-> en == '0 ##1 MONITOR_ENABLE == '0)
        else $error("monitor enabled while frozen");
    chk_ism_gate:    assert property ((en & ~ism_ok) == '0)
        else $error("monitor enabled with set mask bit set");
    chk_full_and:    assert property ((!s.freeze && s.up && !s.cfg[0].pm && plm_ok[0]
                                       && ism_ok[0]) |-> en[0])
        else $error("monitor not enabled with all terms true");

    // status bit checks
    chk_pp_guard:    assert property ((CUR_PRIV_LEVEL != PRIV_KERNEL
                                       && !INTERRUPTION_DELIVERED) |=> $stable(s.pp))
        else $error("system enable changed outside privilege level 0");
    chk_user_instr:  assert property ((SET_USER_MASK && !RESET_USER_MASK && !wr_fire)
                                      |=> s.up ##1 1'b1)
        else $error("set-user-mask did not set user enable");
    chk_intr_copy:   assert property (INTERRUPTION_DELIVERED
                                      |=> s.pp == $past(s.interruption_monitor_default))
        else $error("interruption did not copy default into system enable");

    // counting, freeze and apb checks
    chk_count_step:  assert property ((COUNT_EVENT[0] && en[0] && !wr_fire)
                                      |=> s.cnt[0] == $past(s.cnt[0]) + 32'h1)
        else $error("counter did not step on qualified event");
    chk_count_hold:  assert property ((!COUNT_EVENT[1] && !wr_fire)
                                      |=> $stable(s.cnt[1]))
        else $error("counter moved without event");
    chk_ovf_freeze:  assert property ((|ovf) |=> s.freeze && (s.sts & $past(ovf)) != '0)
        else $error("overflow did not freeze and flag");
    chk_freeze_hold: assert property ((s.freeze && !(wr_fire && PADDR == 12'h000))
                                      |=> s.freeze)
        else $error("freeze cleared without software");
    chk_apb_answer:  assert property ((apb_acc && !s.pready) |=> PREADY ##1 !PREADY)
        else $error("apb answer not one cycle into access");
    chk_err_ready:   assert property (PSLVERR |-> PREADY)
        else $error("slave error without ready");

    // output timing, user clear, capture gating and sticky status checks
    chk_en_late:     assert property (MONITOR_ENABLE == $past(en))
        else $error("monitor enable output not one cycle behind");
    chk_user_clear:  assert property ((RESET_USER_MASK && !wr_fire) |=> !s.up)
        else $error("reset-user-mask did not clear user enable");
    chk_icap_gate:   assert property ((IADDR_EVENT && !en[SLOT_IEAR])
                                      |=> $stable(s.iear_cnt))
        else $error("instruction capture moved while disabled");
    chk_dcap_gate:   assert property ((DADDR_EVENT && !en[SLOT_DEAR])
                                      |=> $stable(s.dear_cnt))
        else $error("data capture moved while disabled");
    // a status bit only leaves through a write to the clear register
    chk_sts_sticky:  assert property (!(wr_fire && PADDR == REG_IRQ_CLR)
                                      |=> (s.sts & $past(s.sts)) == $past(s.sts))
        else $error("interrupt status bit lost without a clear");

    // main scenarios
    cov_count:  cover property (COUNT_EVENT[0] && en[0]);
    cov_ovf:    cover property ((|ovf) ##1 MON_IRQ);
    cov_intr:   cover property (INTERRUPTION_DELIVERED && s.interruption_monitor_default ##1 s.pp);
    cov_trace:  cover property (en[SLOT_TRACE] && s.cfg[SLOT_TRACE].ism[INSTR_SET]);
    cov_capture: cover property (IADDR_EVENT && en[SLOT_IEAR]);

endmodule

// File: logic/pmeq_pkg.sv
// package for the per-monitor enable qualifier: offsets, fields, reset values, carriers
// assumes 32-bit apb data and a 12-bit byte address window
package pmeq_pkg;

    // monitor slots: four generic counters, instruction capture, data capture, trace
    localparam int          NUM_MON     = 7;
    localparam int          NUM_CNT     = 4;
    localparam logic [2:0]  SLOT_IEAR   = 3'h4;
    localparam logic [2:0]  SLOT_DEAR   = 3'h5;
    localparam logic [2:0]  SLOT_TRACE  = 3'h6;   // trace monitor, exempt from set mask
    localparam logic [2:0]  NO_SLOT     = 3'h7;

    // configuration register indices (byte address is four times the index)
    localparam logic [7:0]  CIDX_STATUS0    = 8'h00;
    localparam logic [7:0]  CIDX_STATUS3    = 8'h03;
    localparam logic [7:0]  CIDX_CNT_FIRST  = 8'h04;
    localparam logic [7:0]  CIDX_CNT_LAST   = 8'h07;
    localparam logic [7:0]  CIDX_IEAR       = 8'h0a;
    localparam logic [7:0]  CIDX_DEAR       = 8'h0b;
    localparam logic [7:0]  CIDX_TRACE      = 8'h0c;

    // data register indices
    localparam logic [7:0]  DIDX_IEAR_ADDR  = 8'h00;
    localparam logic [7:0]  DIDX_IEAR_CNT   = 8'h01;
    localparam logic [7:0]  DIDX_DEAR_ADDR  = 8'h02;
    localparam logic [7:0]  DIDX_DEAR_CNT   = 8'h03;
    localparam logic [7:0]  DIDX_CNT_FIRST  = 8'h04;
    localparam logic [7:0]  DIDX_CNT_LAST   = 8'h07;
    localparam logic [7:0]  DIDX_TRACE_FIRST = 8'h08;
    localparam logic [7:0]  DIDX_TRACE_LAST = 8'h10;
    localparam logic [7:0]  DIDX_DEAR_EXT   = 8'h11;

    // address regions
    localparam logic [3:0]  REGION_CFG  = 4'h0;
    localparam logic [3:0]  REGION_DATA = 4'h1;
    localparam logic [11:0] REG_PSR     = 12'h200;
    localparam logic [11:0] REG_DCR     = 12'h204;
    localparam logic [11:0] REG_IRQ_STS = 12'h208;
    localparam logic [11:0] REG_IRQ_CLR = 12'h20c;
    localparam logic [11:0] REG_IRQ_EN  = 12'h210;

    // field positions
    localparam int          CFG_PLM_LSB = 0;
    localparam int          CFG_ISM_LSB = 4;
    localparam int          CFG_PM_BIT  = 6;
    localparam int          ST0_FRZ_BIT = 0;
    localparam int          ST0_OVF_LSB = 4;
    localparam int          USER_MONITOR_ENABLE_BIT  = 0;
    localparam int          SYSTEM_MONITOR_ENABLE_BIT  = 1;
    localparam int          CURRENT_PRIVILEGE_LEVEL_LSB = 2;
    localparam int          INSTRUCTION_SET_INDICATOR_BIT  = 4;
    localparam int          INTERRUPTION_MONITOR_DEFAULT_BIT  = 0;
    localparam logic [1:0]  PRIV_KERNEL = 2'h0;

    // reset values
    localparam logic        RST_FREEZE  = 1'b0;
    localparam logic        RST_UP      = 1'b0;
    localparam logic        RST_PP      = 1'b0;
    localparam logic        RST_INTERRUPTION_MONITOR_DEFAULT  = 1'b0;
    localparam logic [6:0]  RST_CFG     = 7'h00;
    localparam logic [3:0]  RST_IRQ_EN  = 4'h0;

    // per-monitor configuration fields
    typedef struct packed {
        logic       pm;     // privileged_monitor_select
        logic [1:0] ism;    // instruction-set mask
        logic [3:0] plm;    // privilege level mask
    } pmeq_cfg_s;

    // status fields that steer qualification
    typedef struct packed {
        logic       user_monitor_enable;
        logic       system_monitor_enable;
        logic [1:0] current_privilege_level;
        logic       instruction_set_indicator;
    } pmeq_psr_s;

    // whole state of the top module
    typedef struct packed {
        logic                             up;
        logic                             pp;
        logic                             interruption_monitor_default;
        logic                             freeze;
        pmeq_cfg_s [NUM_MON-1:0]          cfg;
        logic [NUM_CNT-1:0][31:0]         cnt;
        logic [31:0]                      iear_addr;
        logic [31:0]                      dear_addr;
        logic [15:0]                      iear_cnt;
        logic [15:0]                      dear_cnt;
        logic [NUM_CNT-1:0]               sts;
        logic [NUM_CNT-1:0]               ien;
        logic [31:0]                      prdata;
        logic                             pready;
        logic                             pslverr;
        logic                             irq;
        logic [NUM_MON-1:0]               en_q;
    } pmeq_state_s;

endpackage

// File: logic/pmeq_qual.sv
// combinational enable qualification for every monitor slot
// assumes status and configuration come from flops in the same clock domain
`timescale 1ns/100ps
module pmeq_qual
    import pmeq_pkg::*;
(
    input  wire pmeq_psr_s                processor_status_reg,
    input  wire logic                     freeze,
    input  wire pmeq_cfg_s [NUM_MON-1:0]  cfg,
    output logic [NUM_MON-1:0]            en
);

    // one and-term per condition, evaluated afresh every cycle
    always_comb begin
        for (int k = 0; k < NUM_MON; k++) begin
            en[k] = !freeze
                && cfg[k].plm[processor_status_reg.current_privilege_level]
                && (!cfg[k].ism[processor_status_reg.instruction_set_indicator]
                    || (3'(k) == SLOT_TRACE))
                && ((!cfg[k].pm && processor_status_reg.user_monitor_enable)
                    || (cfg[k].pm && processor_status_reg.system_monitor_enable));
        end
    end

endmodule

// File: bench/tb.sv
// self-checking bench for the per-monitor enable qualifier
// assumes an apb slave with wait states and enables that show one cycle late
`timescale 1ns/100ps
module tb;
    import pmeq_pkg::*;
    logic               REF_CLK, RESETN, PSEL, PENABLE, PWRITE, INSTR_SET;
    logic [11:0]        PADDR;
    logic [31:0]        PWDATA, PRDATA, seed, rd;
    logic               PREADY, PSLVERR, FROZEN, MON_IRQ, er, up, pp;
    logic               SET_USER_MASK, RESET_USER_MASK, INTERRUPTION_DELIVERED;
    logic [1:0]         CUR_PRIV_LEVEL;
    logic [NUM_CNT-1:0] COUNT_EVENT;
    logic               IADDR_EVENT, DADDR_EVENT;
    logic [31:0]        IADDR_VALUE, DADDR_VALUE;
    logic [NUM_MON-1:0] MONITOR_ENABLE, e;
    logic [6:0]         cfg [NUM_MON];
    logic [31:0]        cnt [NUM_CNT];
    int                 error_cnt, checks_done;
    pmeq_top DUT (.REF_CLK(REF_CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .CUR_PRIV_LEVEL(CUR_PRIV_LEVEL), .INSTR_SET(INSTR_SET),
        .SET_USER_MASK(SET_USER_MASK), .RESET_USER_MASK(RESET_USER_MASK),
        .INTERRUPTION_DELIVERED(INTERRUPTION_DELIVERED), .COUNT_EVENT(COUNT_EVENT),
        .IADDR_EVENT(IADDR_EVENT), .IADDR_VALUE(IADDR_VALUE), .DADDR_EVENT(DADDR_EVENT),
        .DADDR_VALUE(DADDR_VALUE),
        .MONITOR_ENABLE(MONITOR_ENABLE), .FROZEN(FROZEN), .MON_IRQ(MON_IRQ));
    // core clock, 40 ns period
    initial begin
        REF_CLK = 1'b0;
        forever #20 REF_CLK = ~REF_CLK;
    end
    // xorshift source for repeatable stimulus
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    // byte address of the configuration word of a slot
    function automatic logic [11:0] caddr(input int k);
        return (k < NUM_CNT) ? 12'h010 + 12'(4 * k) : 12'h028 + 12'(4 * (k - NUM_CNT));
    endfunction
    // expected slot enables while not frozen
    function automatic logic [NUM_MON-1:0] exp_en(input logic [1:0] lv, input logic is);
        logic [NUM_MON-1:0] r;
        for (int k = 0; k < NUM_MON; k++) begin
            r[k] = cfg[k][lv] && (!cfg[k][4 + is] || k == int'(SLOT_TRACE))
                   && (cfg[k][6] ? pp : up);
        end
        return r;
    endfunction
    // count a comparison, report a mismatch at once
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        checks_done++;
        if (g !== x) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, x, g);
        end
    endtask
    // one apb transfer, request held until ready is seen
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge REF_CLK);
        {PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, w, a, d};
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        // ready is looked at on the rising edge at which the transfer completes
        do begin
            @(posedge REF_CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 50);
        rd = PRDATA;
        er = PSLVERR;
        {PSEL, PENABLE} <= 2'h0;
        if (n >= 50) chk("apb ready", 32'h1, 32'h0);
    endtask
    // read a word and compare the masked bits
    task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] m,
                         input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(nm, x, rd & m);
    endtask
    // one-cycle pulse on the event and mode inputs
    task automatic pulse(input logic [6:0] p);
        @(posedge REF_CLK);
        {COUNT_EVENT, INTERRUPTION_DELIVERED, RESET_USER_MASK, SET_USER_MASK} <= p;
        @(posedge REF_CLK);
        {COUNT_EVENT, INTERRUPTION_DELIVERED, RESET_USER_MASK, SET_USER_MASK} <= 7'h0;
    endtask
    // one-cycle capture events with an address for each unit
    task automatic cap(input logic [31:0] v);
        @(posedge REF_CLK);
        {IADDR_EVENT, DADDR_EVENT, IADDR_VALUE, DADDR_VALUE} <= {2'h3, v, ~v};
        @(posedge REF_CLK);
        {IADDR_EVENT, DADDR_EVENT} <= 2'h0;
    endtask
    // let registered outputs settle, then look between edges
    task automatic settle;
        repeat (3) @(posedge REF_CLK);
        @(negedge REF_CLK);
    endtask
    // verdict and end of run
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // cut a hang short
    initial begin
        repeat (40000) @(posedge REF_CLK);
        error_cnt++;
        test_done;
    end
    // reset, then the tests
    initial begin
        error_cnt = 0;
        checks_done = 0;
        seed = 32'h4a3d;
        {RESETN, PSEL, PENABLE, PWRITE, INSTR_SET, PADDR, PWDATA, CUR_PRIV_LEVEL} = '0;
        {COUNT_EVENT, INTERRUPTION_DELIVERED, RESET_USER_MASK, SET_USER_MASK} = 7'h0;
        {IADDR_EVENT, DADDR_EVENT, IADDR_VALUE, DADDR_VALUE} = '0;
        {up, pp} = 2'h0;
        for (int k = 0; k < NUM_CNT; k++) cnt[k] = 32'h0;
        repeat (8) @(posedge REF_CLK);
        RESETN <= 1'b1;
        // reset values, a status word and an unmapped place
        rdchk("cfg reset", caddr(0), 32'hffffffff, 32'h0);
        rdchk("status word 3", 12'h00c, 32'hffffffff, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, er});
        $display("test reset done");
        // system enable only at level 0, user enable by the mask pulses
        CUR_PRIV_LEVEL <= 2'h3;
        apb(1'b1, REG_PSR, 32'h2);
        rdchk("system enable at level 3", REG_PSR, 32'h2, 32'h0);
        CUR_PRIV_LEVEL <= 2'h0;
        apb(1'b1, REG_PSR, 32'h2);
        rdchk("system enable at level 0", REG_PSR, 32'h2, 32'h2);
        pulse(7'h1);
        rdchk("user enable set", REG_PSR, 32'h1, 32'h1);
        pulse(7'h3);
        rdchk("user enable clear", REG_PSR, 32'h1, 32'h0);
        for (int v = 0; v < 2; v++) begin
            apb(1'b1, REG_DCR, 32'(v));
            pulse(7'h4);
            rdchk("system enable copy", REG_PSR, 32'h2, 32'(2 * v));
        end
        $display("test global enables done");
        // random configurations, levels and set indicators
        for (int it = 0; it < 24; it++) begin
            CUR_PRIV_LEVEL <= 2'h0;
            for (int k = 0; k < NUM_MON; k++) begin
                seed = xs(seed);
                cfg[k] = (it < 2) ? {it[0], 6'h3f} : seed[6:0];
                apb(1'b1, caddr(k), {25'h0, cfg[k]});
            end
            seed = xs(seed);
            {up, pp} = seed[1:0];
            apb(1'b1, REG_PSR, {30'h0, pp, up});
            CUR_PRIV_LEVEL <= seed[3:2];
            INSTR_SET <= seed[4];
            e = exp_en(seed[3:2], seed[4]);
            settle;
            chk("monitor enable", {25'h0, e}, {25'h0, MONITOR_ENABLE});
            pulse(7'h78);
            for (int k = 0; k < NUM_CNT; k++) begin
                cnt[k] = cnt[k] + {31'h0, e[k]};
                rdchk("counter", 12'h110 + 12'(4 * k), 32'hffffffff, cnt[k]);
            end
        end
        $display("test random qualification done");
        // overflow freezes every monitor until the freeze bit is cleared
        CUR_PRIV_LEVEL <= 2'h0;
        INSTR_SET <= 1'b0;
        apb(1'b1, caddr(0), 32'h01);
        apb(1'b1, REG_PSR, 32'h1);
        apb(1'b1, REG_IRQ_EN, 32'h1);
        apb(1'b1, 12'h110, 32'hffffffff);
        pulse(7'h08);
        settle;
        chk("frozen", 32'h1, {31'h0, FROZEN});
        chk("enables frozen", 32'h0, {25'h0, MONITOR_ENABLE});
        chk("irq raised", 32'h1, {31'h0, MON_IRQ});
        pulse(7'h08);
        rdchk("counter while frozen", 12'h110, 32'hffffffff, 32'h0);
        apb(1'b1, REG_IRQ_EN, 32'h0);
        settle;
        chk("irq masked", 32'h0, {31'h0, MON_IRQ});
        apb(1'b1, REG_IRQ_EN, 32'h1);
        apb(1'b1, REG_IRQ_CLR, 32'h1);
        rdchk("irq status cleared", REG_IRQ_STS, 32'hf, 32'h0);
        apb(1'b1, 12'h000, 32'h0);
        pulse(7'h08);
        rdchk("counter after thaw", 12'h110, 32'hffffffff, 32'h1);
        $display("test freeze done");
        // native-only set mask: trace slot stays enabled, instruction capture is blocked
        apb(1'b1, caddr(SLOT_IEAR), 32'h1f);
        apb(1'b1, caddr(SLOT_TRACE), 32'h1f);
        settle;
        e = MONITOR_ENABLE;
        chk("trace exempt", 32'h2, {30'h0, e[SLOT_TRACE], e[SLOT_IEAR]});
        // capture units take an address only when the set mask lets them
        apb(1'b1, caddr(SLOT_IEAR), 32'h2f);
        apb(1'b1, caddr(SLOT_DEAR), 32'h2f);
        seed = xs(seed);
        cap(seed);
        rdchk("instr capture", 12'h100, 32'hffffffff, seed);
        rdchk("data capture", 12'h108, 32'hffffffff, ~seed);
        rdchk("data capture count", 12'h10c, 32'hffff, 32'h1);
        INSTR_SET <= 1'b1;
        cap(~seed);
        rdchk("instr capture blocked", 12'h100, 32'hffffffff, seed);
        rdchk("instr capture count", 12'h104, 32'hffff, 32'h1);
        $display("test capture done");
        test_done;
    end
endmodule
